// File: verilog/usf_status_flags.sv
// Status flags, service requests, break interlock and interrupt of the serial port
// Functional notes
// - Transmit service flag is low when the transmit FIFO holds five or more or tx is off.
// - Transmit service flag is high when tx is enabled and the FIFO holds four or fewer.
// - Transmit service flag drives a DMA request and, if tx_int_enable is one, an interrupt.
// - Receive service flag sets with rx enabled and five or more entries, giving DMA and, if its interrupt enable is one, irq.
// - Receive service flag clears when rx is off or occupancy is below the threshold.
// - Idle flag sets after three frame times with no data, rx enabled and FIFO not empty.
// - Idle flag stays clear while the receiver is busy, the FIFO is empty or rx is off.
// - Break-begin flag sets on a zero character with zero parity and stop bits.
// - Break-begin arms break-end and lets only one zero framing-error character be stored.
// - Break-end flag sets on a rising receive-pin edge while the break interlock is set.
// - Break-end re-arms break-begin detection and resumes storing characters.
// - FIFO-error flag sets when a bottom-four entry has an error bit, and blocks rx DMA.
// - With no error in the bottom four entries the error flag is clear and rx DMA allowed.
// - Transmit service, receive service and FIFO-error flags ignore writes.
`timescale 1ns/10ps
`include "usf_consts.svh"
module usf_status_flags
  import usf_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // FIFO and receiver state
  input wire logic [3:0] tx_count_i,
  input wire logic [3:0] rx_count_i,
  input wire logic [`USF_ERR_DEPTH-1:0] rx_entry_err_i,
  input wire logic rx_busy_i,
  input wire usf_rx_char_t rx_char_i,
  // Serial receive pin
  input wire logic rxd_i,
  // Requests
  output logic rx_store_o,
  output usf_dma_t dma_o,
  output logic irq_o
);
  logic rxd_s;
  logic rxd_prev;
  logic [5:0] status;
  logic [5:0] mask;
  logic [3:0] ctrl;
  logic [15:0] frame_cycles;
  logic [15:0] bit_cnt;
  logic [1:0] frame_cnt;
  usf_brk_state_t brk_state;
  logic tx_en;
  logic rx_en;
  logic next_tx_service;
  logic next_rx_service;
  logic next_err;
  logic null_char;
  logic idle_hit;
  logic brk_start;
  logic brk_end;
  logic wr_status;
  logic [5:0] clr;
  logic [5:0] raise;
  logic tx_service_flag;
  logic rx_service_flag;
  logic rx_idle_flag;
  logic break_begin_flag;
  logic break_end_flag;
  logic fifo_error_flag;
  logic idle_keep;
  logic [5:0] pend;

  assign tx_en = ctrl[`USF_BIT_TX_EN];
  assign rx_en = ctrl[`USF_BIT_RX_EN];
  assign wr_status = wr_i && (addr_i == `USF_ADDR_STATUS);

  // Status word as software sees it
  always_comb begin
    status = 6'h00;
    status[`USF_BIT_TX_SERVICE] = tx_service_flag;
    status[`USF_BIT_RX_SERVICE] = rx_service_flag;
    status[`USF_BIT_IDLE] = rx_idle_flag;
    status[`USF_BIT_BRB] = break_begin_flag;
    status[`USF_BIT_BRE] = break_end_flag;
    status[`USF_BIT_ERR] = fifo_error_flag;
  end

  usf_sync u_rxd_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .d_i(rxd_i),
    .q_o(rxd_s)
  );

  // Level flags
  always_comb begin
    next_tx_service = tx_en && (tx_count_i <= `USF_TX_HALF);
    next_rx_service = rx_en && (rx_count_i >= `USF_RX_THRESH);
    next_err = |rx_entry_err_i;
  end

  // Break and idle events
  always_comb begin
    null_char = rx_char_i.valid && (rx_char_i.data == 8'h00) && rx_char_i.parity_zero
      && rx_char_i.stop_zero;
    brk_start = null_char && (brk_state == USF_BRK_IDLE);
    brk_end = (brk_state == USF_BRK_ACTIVE) && rxd_s && !rxd_prev;
    idle_hit = rx_en && !rx_busy_i && !rx_char_i.valid && (rx_count_i != 4'h0)
      && (frame_cnt == (`USF_IDLE_FRAMES - 2'h1)) && (bit_cnt >= frame_cycles);
    idle_keep = rx_en && !rx_busy_i && (rx_count_i != 4'h0);
  end

  // Write-one-to-clear of sticky bits only
  always_comb begin
    clr = 6'h00;
    if (wr_status) begin
      clr[`USF_BIT_IDLE] = wdata_i[`USF_BIT_IDLE];
      clr[`USF_BIT_BRB] = wdata_i[`USF_BIT_BRB];
      clr[`USF_BIT_BRE] = wdata_i[`USF_BIT_BRE];
    end
    raise = 6'h00;
    raise[`USF_BIT_IDLE] = idle_hit;
    raise[`USF_BIT_BRB] = brk_start;
    raise[`USF_BIT_BRE] = brk_end;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rxd_prev <= 1'b1;
    end else begin
      rxd_prev <= rxd_s;
    end
  end

  // Frame time counter for idle detection
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt <= 16'h0000;
      frame_cnt <= 2'h0;
    end else if (!rx_en || rx_busy_i || rx_char_i.valid || rx_count_i == 4'h0) begin
      bit_cnt <= 16'h0000;
      frame_cnt <= 2'h0;
    end else if (frame_cnt != `USF_IDLE_FRAMES) begin
      if (bit_cnt >= frame_cycles) begin
        bit_cnt <= 16'h0000;
        frame_cnt <= frame_cnt + 2'h1;
      end else begin
        bit_cnt <= bit_cnt + 16'h0001;
      end
    end
  end

  // Break interlock
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      brk_state <= USF_BRK_IDLE;
    end else begin
      case (brk_state)
        USF_BRK_IDLE: begin
          if (brk_start) begin
            brk_state <= USF_BRK_ACTIVE;
          end
        end
        USF_BRK_ACTIVE: begin
          if (brk_end) begin
            brk_state <= USF_BRK_IDLE;
          end
        end
        default: begin
          brk_state <= USF_BRK_IDLE;
        end
      endcase
    end
  end

  // Store strobe into receive FIFO
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_store_o <= 1'b0;
    end else begin
      rx_store_o <= rx_char_i.valid && rx_en && (brk_state == USF_BRK_IDLE);
    end
  end

  // Transmit service flag, read-only
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_service_flag <= 1'b0;
    end else begin
      tx_service_flag <= next_tx_service;
    end
  end

  // Receive service flag, read-only
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_service_flag <= 1'b0;
    end else begin
      rx_service_flag <= next_rx_service;
    end
  end

  // FIFO error flag, read-only
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      fifo_error_flag <= 1'b0;
    end else begin
      fifo_error_flag <= next_err;
    end
  end

  // Idle flag; one-shot set beats clear
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_idle_flag <= 1'b0;
    end else begin
      rx_idle_flag <= raise[`USF_BIT_IDLE]
        || (rx_idle_flag && !clr[`USF_BIT_IDLE] && idle_keep);
    end
  end

  // Break-begin flag; set beats clear
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      break_begin_flag <= 1'b0;
    end else begin
      break_begin_flag <= raise[`USF_BIT_BRB]
        || (break_begin_flag && !clr[`USF_BIT_BRB]);
    end
  end

  // Break-end flag; set beats clear
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      break_end_flag <= 1'b0;
    end else begin
      break_end_flag <= raise[`USF_BIT_BRE]
        || (break_end_flag && !clr[`USF_BIT_BRE]);
    end
  end

  // Software registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mask <= `USF_MASK_RESET;
      ctrl <= `USF_CTRL_RESET;
      frame_cycles <= `USF_FRAME_RESET;
    end else if (wr_i) begin
      if (addr_i == `USF_ADDR_MASK) begin
        mask <= wdata_i[5:0];
      end else if (addr_i == `USF_ADDR_CTRL) begin
        ctrl <= wdata_i[3:0];
      end else if (addr_i == `USF_ADDR_FRAME) begin
        frame_cycles <= wdata_i;
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      if (addr_i == `USF_ADDR_STATUS) begin
        rdata_o <= {10'h000, status};
      end else if (addr_i == `USF_ADDR_MASK) begin
        rdata_o <= {10'h000, mask};
      end else if (addr_i == `USF_ADDR_CTRL) begin
        rdata_o <= {12'h000, ctrl};
      end else if (addr_i == `USF_ADDR_FRAME) begin
        rdata_o <= frame_cycles;
      end else begin
        rdata_o <= 16'h0000;
      end
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  // DMA requests
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      dma_o <= '0;
    end else begin
      dma_o.tx_dma <= next_tx_service;
      dma_o.rx_dma <= next_rx_service && !next_err;
    end
  end

  // Pending sources; service flags also need their interrupt enables
  always_comb begin
    pend = 6'h00;
    pend[`USF_BIT_TX_SERVICE] = next_tx_service && ctrl[`USF_BIT_TX_INT_EN];
    pend[`USF_BIT_RX_SERVICE] = next_rx_service && ctrl[`USF_BIT_RX_INT_EN];
    pend[`USF_BIT_IDLE] = rx_idle_flag;
    pend[`USF_BIT_BRB] = break_begin_flag;
    pend[`USF_BIT_BRE] = break_end_flag;
    pend[`USF_BIT_ERR] = next_err;
  end

  // Level interrupt from unmasked pending sources
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(pend & mask);
    end
  end
endmodule // usf_status_flags

// File: verilog/usf_consts.svh
// Offsets, field positions, reset values and timing counts of the status flag block
`ifndef USF_CONSTS_SVH
`define USF_CONSTS_SVH

`define USF_ADDR_STATUS 4'h0
`define USF_ADDR_MASK 4'h1
`define USF_ADDR_CTRL 4'h2
`define USF_ADDR_FRAME 4'h3

`define USF_BIT_TX_SERVICE 0
`define USF_BIT_RX_SERVICE 1
`define USF_BIT_IDLE 2
`define USF_BIT_BRB 3
`define USF_BIT_BRE 4
`define USF_BIT_ERR 5

`define USF_BIT_TX_EN 0
`define USF_BIT_RX_EN 1
`define USF_BIT_TX_INT_EN 2
`define USF_BIT_RX_INT_EN 3

`define USF_TX_HALF 4'h4
`define USF_RX_THRESH 4'h5
`define USF_IDLE_FRAMES 2'h3
`define USF_ERR_DEPTH 4
`define USF_MASK_RESET 6'h00
`define USF_CTRL_RESET 4'h0
`define USF_FRAME_RESET 16'h0457

`endif

// File: verilog/usf_pkg.sv
// Types shared by the status flag block
package usf_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic parity_zero;
    logic stop_zero;
    logic framing_err;
    logic valid;
  } usf_rx_char_t;

  typedef struct packed {
    logic tx_dma;
    logic rx_dma;
  } usf_dma_t;

  typedef enum logic [1:0] {
    USF_BRK_IDLE,
    USF_BRK_ACTIVE
  } usf_brk_state_t;
endpackage

// File: verilog/usf_sync.sv
// Two flip-flop synchroniser for one pin level
`timescale 1ns/10ps
module usf_sync (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Level
  input wire logic d_i,
  output logic q_o
);
  logic meta;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= 1'b1;
      q_o <= 1'b1;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule // usf_sync

// File: tb/usf_checker.sv
// Port assertions of the status flag block
`timescale 1ns/10ps
`include "usf_consts.svh"
module usf_checker
  import usf_pkg::*;
(
  // Clock, reset and register port
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  // Fifo state, characters and requests
  input wire logic [3:0] tx_count_i,
  input wire logic [3:0] rx_count_i,
  input wire logic [`USF_ERR_DEPTH-1:0] rx_entry_err_i,
  input wire logic rx_busy_i,
  input wire usf_rx_char_t rx_char_i,
  input wire logic rxd_i,
  input wire logic rx_store_o,
  input wire usf_dma_t dma_o,
  input wire logic irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic nul;
  assign nul = rx_char_i.valid && rx_char_i.data == 8'h00
    && rx_char_i.parity_zero && rx_char_i.stop_zero;
  tx_full_a: assert property (
    tx_count_i > 4'h4 |=> !dma_o.tx_dma) else $error("tx dma while full");
  tx_rise_a: assert property (
    $rose(dma_o.tx_dma) |-> $past(tx_count_i) <= 4'h4) else $error("tx dma cause");
  rx_low_a: assert property (
    rx_count_i < 4'h5 |=> !dma_o.rx_dma) else $error("rx dma below threshold");
  rx_err_a: assert property (
    |rx_entry_err_i |=> !dma_o.rx_dma) else $error("rx dma with error");
  rx_dma_cause_a: assert property (
    dma_o.rx_dma |-> $past(rx_count_i) >= 4'h5 && $past(rx_entry_err_i) == 4'h0)
    else $error("rx dma cause");
  store_cause_a: assert property (
    rx_store_o |-> $past(rx_char_i.valid)) else $error("store without char");
  brk_block_a: assert property (
    nul && !rxd_i ##1 (!rxd_i)[*4] ##0 nul |=> !rx_store_o)
    else $error("second null stored");
  tx_flag_ro_a: assert property (
    rd_i && addr_i == 4'h0 && $past(tx_count_i) > 4'h4 |=> !rdata_o[0])
    else $error("tx flag read");
  cover property (nul ##1 rx_store_o);
  cover property ($rose(dma_o.tx_dma));
  cover property ($rose(irq_o));
endmodule // usf_checker

bind usf_status_flags usf_checker i_chk (.*);

// File: tb/usf_tx_model.sv
// Remote transmitter model driving received characters and the pin
`timescale 1ns/10ps
module usf_tx_model
  import usf_pkg::*;
(
  // Clock
  input wire logic clock_i,
  // Receiver side
  output usf_rx_char_t rx_char_o,
  output logic rxd_o
);
  initial begin
    rx_char_o = '0;
    rxd_o = 1'b1;
  end
  // One character; a null pulls the line low and leaves it low until rise
  task automatic send(input logic [7:0] d, input logic fe);
    @(posedge clock_i);
    rx_char_o <= '{d, d == 8'h00, d == 8'h00, fe, 1'b1};
    if (d == 8'h00) begin
      rxd_o <= 1'b0;
    end
    @(posedge clock_i);
    rx_char_o <= '{~d, 1'b0, 1'b0, 1'b0, 1'b0};
    repeat (2) @(posedge clock_i);
  endtask
  // End of break
  task automatic rise;
    @(posedge clock_i);
    rxd_o <= 1'b1;
  endtask
endmodule // usf_tx_model

// File: tb/usf_status_flags_tb.sv
// Self-checking bench of the status flag block
`timescale 1ns/10ps
`include "usf_consts.svh"
module usf_status_flags_tb
  import usf_pkg::*;
;
  logic clock_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, rx_busy_i = 1;
  logic [3:0] addr_i = 4'h0, tx_count_i = 4'h8, rx_count_i = 4'h0, rx_entry_err_i = 4'h0;
  logic [15:0] wdata_i = 16'h0, rdata_o, q, s;
  logic rx_store_o, irq_o, rxd_i;
  usf_dma_t dma_o;
  usf_rx_char_t rx_char_i;
  int failures = 0, n_tests = 0, seed = 32'h5ddd, n_store = 0, i;
  initial forever #5 clock_i = ~clock_i;
  usf_status_flags i_dut (.*);
  usf_tx_model i_tx (.clock_i(clock_i), .rx_char_o(rx_char_i), .rxd_o(rxd_i));
  always @(posedge clock_i) if (rx_store_o === 1'b1) n_store++;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 q = rdata_o;
  endtask
  function automatic logic [15:0] exp_st(input logic [3:0] t, r, e, input logic en);
    return {10'h0, |e, 3'h0, en && r >= 4'h5, en && t <= 4'h4};
  endfunction
  task automatic test_done;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(4'h9);
    chk(q, 16'h0);
    wr(`USF_ADDR_FRAME, 16'h0004);
    wr(`USF_ADDR_MASK, 16'h003F);
    for (int en = 0; en < 2; en++) begin
      wr(`USF_ADDR_CTRL, en == 1 ? 16'h000F : 16'h0000);
      for (i = 0; i < 12; i++) begin
        @(posedge clock_i);
        tx_count_i <= i < 2 ? 4'h4 + 4'(i) : 4'($random(seed));
        rx_count_i <= i < 2 ? 4'h5 - 4'(i) : 4'($random(seed));
        rx_entry_err_i <= i % 3 == 2 ? 4'h1 << (i % 4) : 4'h0;
        wr(`USF_ADDR_STATUS, 16'h0023);
        s = exp_st(tx_count_i, rx_count_i, rx_entry_err_i, en == 1);
        #1 chk({14'h0, dma_o}, {14'h0, s[0], s[1] && !s[5]});
        chk(irq_o, |s);
        rd(`USF_ADDR_STATUS);
        chk(q & 16'h0023, s);
      end
    end
    $display("service flags done");
    @(posedge clock_i);
    tx_count_i <= 4'h8;
    rx_count_i <= 4'h1;
    rx_entry_err_i <= 4'h0;
    rx_busy_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    rd(`USF_ADDR_STATUS);
    chk(q, 16'h0);
    repeat (10) @(posedge clock_i);
    rd(`USF_ADDR_STATUS);
    chk(q, 16'h0004);
    chk(irq_o, 1'b1);
    wr(`USF_ADDR_STATUS, 16'h0000);
    rd(`USF_ADDR_STATUS);
    chk(q, 16'h0004);
    @(posedge clock_i);
    rx_busy_i <= 1'b1;
    rd(`USF_ADDR_STATUS);
    chk(q, 16'h0);
    @(posedge clock_i);
    rx_busy_i <= 1'b0;
    repeat (20) @(posedge clock_i);
    rd(`USF_ADDR_STATUS);
    chk(q, 16'h0004);
    wr(`USF_ADDR_STATUS, 16'h0004);
    rd(`USF_ADDR_STATUS);
    chk(q, 16'h0);
    @(posedge clock_i);
    rx_busy_i <= 1'b1;
    $display("idle done");
    i_tx.send(8'h00, 1'b0);
    i_tx.send(8'h00, 1'b1);
    i_tx.send(8'h00, 1'b1);
    chk(n_store, 1);
    rd(`USF_ADDR_STATUS);
    chk(q, 16'h0008);
    chk(irq_o, 1'b1);
    wr(`USF_ADDR_STATUS, 16'h0008);
    rd(`USF_ADDR_STATUS);
    chk(q, 16'h0);
    i_tx.rise;
    repeat (6) @(posedge clock_i);
    rd(`USF_ADDR_STATUS);
    chk(q, 16'h0010);
    i_tx.send(8'h41, 1'b0);
    chk(n_store, 2);
    i_tx.send(8'h00, 1'b0);
    rd(`USF_ADDR_STATUS);
    chk(q, 16'h0018);
    wr(`USF_ADDR_STATUS, 16'h0018);
    rd(`USF_ADDR_STATUS);
    chk(q, 16'h0);
    chk(irq_o, 1'b0);
    $display("break done");
    test_done;
  end
endmodule // usf_status_flags_tb
